// ==== core/acs_top.sv ====
// Functional notes
// - Reference code: pin, supply, reserved, internal
// - Reference and channel changes wait for completion
// - Left-adjust bit reshapes readable result immediately
// - Codes 0 to 7 are single-ended inputs
// - Codes 8 to 15 are gained differential pairs
// - Upper codes: 1x pairs, bandgap, ground
// - Enable runs converter; clearing it aborts conversion
// - First conversion 25 cycles, later ones 13
// - Start bit reads one while converting
// - Auto-trigger starts on selected trigger rising edge
// - Complete flag set at every completion, even with result locked
// - Interrupt when flag, enable and global enable
// - Flag cleared by vector or writing one
// - Prescaler divides system clock by 2 to 128
// - Result byte layout depends on adjust bit
// - Low byte read locks result until high read
// - Differential results kept as two's complement
// - Free-running source never makes a trigger edge
`timescale 1ns/10ps
`include "acs_cfg.svh"
module acs_top
  import acs_pkg::*;
#(
  parameter int RES_W = 10,
  parameter int TRIG_N = 7
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [RES_W-1:0] sarData,
  input wire logic [TRIG_N-1:0] trigSources,
  input wire logic globalIrqEnable,
  input wire logic irqVectorAck,
  output logic convIrq,
  output logic converterOn,
  output logic sarStart,
  output logic sarTick,
  output logic refExtPin,
  output logic refSupply,
  output logic refInternal,
  output logic [2:0] muxPos,
  output logic [2:0] muxNeg,
  output logic diffMode,
  output acs_gain_t gainSel,
  output logic bandgapSel,
  output logic groundSel
);

  function automatic logic [15:0] acs_present(input logic [9:0] r, input logic la);
    acs_present = la ? {r, 6'h00} : {6'h00, r};
  endfunction : acs_present

  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [7:0] crs_reg, crs_next;
  logic en_reg, en_next;
  logic ate_reg, ate_next;
  logic flag_reg, flag_next;
  logic ie_reg, ie_next;
  logic [2:0] ps_reg, ps_next;
  logic [2:0] ts_reg, ts_next;
  logic [9:0] result_reg, result_next;
  logic lock_reg, lock_next;
  logic firstPend_reg, firstPend_next;
  logic [4:0] len_reg, len_next;
  logic [4:0] tickCnt_reg, tickCnt_next;
  logic trigPrev_reg;
  logic irq_reg, irq_next;
  logic start_reg;
  logic [1:0] activeRef_reg, activeRef_next;
  logic [4:0] activeMux_reg, activeMux_next;
  acs_state_t state_reg, state_next;
  logic refExt_reg, refSup_reg, refInt_reg;
  logic [2:0] pos_reg, pos_next, neg_reg, neg_next;
  logic diff_reg, diff_next, bg_reg, bg_next, gnd_reg, gnd_next;
  acs_gain_t gain_reg, gain_next;

  logic done, wrCcs, busy, trigLevel, trigEdge, complete, start, blocked, freeRun, tick;
  logic [15:0] shown;

  // Registers answer one cycle into the access phase so prdata is a flop
  assign done = psel && penable && pready_reg;
  assign wrCcs = done && pwrite && paddr == `ACS_OFS_CCS;
  assign busy = state_reg == ACS_CONV;
  assign shown = acs_present(result_reg, crs_reg[`ACS_LADJ_BIT]);
  assign freeRun = ate_reg && ts_reg == 3'h0;
  // Source zero maps to a constant low, so no edge can appear from it
  assign trigLevel = (ts_reg == 3'h0) ? 1'b0 : trigSources[3'(ts_reg - 3'h1)];
  assign trigEdge = trigLevel && !trigPrev_reg;
  assign complete = busy && tick && tickCnt_reg == len_reg - 5'h01;
  // A pending low-byte read also blocks, since its data was sampled a cycle early
  assign blocked = lock_reg || (psel && !pwrite && paddr == `ACS_OFS_RLO);

  acs_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(en_reg),
    .clear(start),
    .prescaleSel(ps_reg),
    .tick(tick)
  );

  always_comb
  begin
    pready_next = psel && penable && !pready_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (pready_next)
    begin
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        `ACS_OFS_CRS: prdata_next[7:0] = crs_reg;
        `ACS_OFS_CCS: prdata_next[7:0] = {en_reg, busy, ate_reg, flag_reg, ie_reg, ps_reg};
        `ACS_OFS_RLO: prdata_next[7:0] = shown[7:0];
        `ACS_OFS_RHI: prdata_next[7:0] = shown[15:8];
        `ACS_OFS_TRG: prdata_next[7:0] = {ts_reg, 5'h00};
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  always_comb
  begin
    crs_next = crs_reg;
    en_next = en_reg;
    ate_next = ate_reg;
    ie_next = ie_reg;
    ps_next = ps_reg;
    ts_next = ts_reg;
    lock_next = lock_reg;
    if (done && pwrite)
    begin
      unique case (paddr)
        `ACS_OFS_CRS: crs_next = pwdata[7:0];
        `ACS_OFS_CCS:
        begin
          en_next = pwdata[`ACS_EN_BIT];
          ate_next = pwdata[`ACS_ATE_BIT];
          ie_next = pwdata[`ACS_IE_BIT];
          ps_next = pwdata[`ACS_PS_HI:0];
        end
        `ACS_OFS_TRG: ts_next = pwdata[`ACS_TS_HI:`ACS_TS_LO];
        default: ;
      endcase
    end
    if (done && !pwrite && paddr == `ACS_OFS_RLO)
    begin
      lock_next = 1'b1;
    end
    if (done && !pwrite && paddr == `ACS_OFS_RHI)
    begin
      lock_next = 1'b0;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    tickCnt_next = tickCnt_reg;
    len_next = len_reg;
    firstPend_next = firstPend_reg;
    result_next = result_reg;
    flag_next = flag_reg;
    activeRef_next = activeRef_reg;
    activeMux_next = activeMux_reg;
    start = 1'b0;
    if (en_next && !en_reg)
    begin
      firstPend_next = 1'b1;
    end
    if (busy && tick)
    begin
      tickCnt_next = tickCnt_reg + 5'h01;
    end
    if (wrCcs && pwdata[`ACS_IF_BIT] || irqVectorAck)
    begin
      flag_next = 1'b0;
    end
    if (complete)
    begin
      if (!blocked)
      begin
        result_next = sarData[9:0];
      end
      flag_next = 1'b1;
      state_next = ACS_IDLE;
    end
    // Busy writes of the start bit are ignored except in the completing cycle; zero writes do nothing
    if (en_next && (!busy || complete) &&
        ((wrCcs && pwdata[`ACS_SC_BIT]) || (ate_reg && trigEdge) || (complete && freeRun)))
    begin
      start = 1'b1;
      state_next = ACS_CONV;
      tickCnt_next = 5'h00;
      len_next = firstPend_next ? `ACS_FIRST_CYC : `ACS_NORM_CYC;
      firstPend_next = 1'b0;
    end
    if (!en_next)
    begin
      state_next = ACS_IDLE;
      tickCnt_next = 5'h00;
    end
    // Held through a conversion, sampled again only between conversions
    if (state_next == ACS_IDLE || start)
    begin
      activeRef_next = crs_reg[`ACS_REF_HI:`ACS_REF_LO];
      activeMux_next = crs_reg[`ACS_MUX_HI:0];
    end
    irq_next = flag_reg && ie_reg && globalIrqEnable;
  end

  always_comb
  begin
    pos_next = activeMux_reg[2:0];
    neg_next = 3'h0;
    diff_next = 1'b1;
    gain_next = ACS_GAIN_1;
    bg_next = 1'b0;
    gnd_next = 1'b0;
    unique case (activeMux_reg[4:3])
      2'b00: diff_next = 1'b0;
      2'b01:
      begin
        pos_next = {1'b0, activeMux_reg[2], activeMux_reg[0]};
        neg_next = activeMux_reg[2] ? 3'h2 : 3'h0;
        gain_next = activeMux_reg[1] ? ACS_GAIN_200 : ACS_GAIN_10;
      end
      2'b10: neg_next = 3'h1;
      2'b11:
      begin
        neg_next = 3'h2;
        if (activeMux_reg == `ACS_MUX_BANDGAP || activeMux_reg == `ACS_MUX_GROUND)
        begin
          diff_next = 1'b0;
          pos_next = 3'h0;
          neg_next = 3'h0;
          bg_next = activeMux_reg == `ACS_MUX_BANDGAP;
          gnd_next = activeMux_reg == `ACS_MUX_GROUND;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      crs_reg <= `ACS_CRS_RST;
      {en_reg, ate_reg, ie_reg} <= 3'h0;
      ps_reg <= 3'(`ACS_CCS_RST);
      ts_reg <= `ACS_TRG_RST;
      lock_reg <= 1'b0;
      state_reg <= ACS_IDLE;
      tickCnt_reg <= 5'h00;
      len_reg <= `ACS_NORM_CYC;
      firstPend_reg <= 1'b0;
      result_reg <= 10'h000;
      flag_reg <= 1'b0;
      irq_reg <= 1'b0;
      trigPrev_reg <= 1'b0;
      start_reg <= 1'b0;
      activeRef_reg <= 2'h0;
      activeMux_reg <= 5'h00;
      {refExt_reg, refSup_reg, refInt_reg} <= 3'h0;
      pos_reg <= 3'h0;
      neg_reg <= 3'h0;
      {diff_reg, bg_reg, gnd_reg} <= 3'h0;
      gain_reg <= ACS_GAIN_1;
    end
    else
    begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      crs_reg <= crs_next;
      en_reg <= en_next;
      ate_reg <= ate_next;
      ie_reg <= ie_next;
      ps_reg <= ps_next;
      ts_reg <= ts_next;
      lock_reg <= lock_next;
      state_reg <= state_next;
      tickCnt_reg <= tickCnt_next;
      len_reg <= len_next;
      firstPend_reg <= firstPend_next;
      result_reg <= result_next;
      flag_reg <= flag_next;
      irq_reg <= irq_next;
      trigPrev_reg <= trigLevel;
      start_reg <= start;
      activeRef_reg <= activeRef_next;
      activeMux_reg <= activeMux_next;
      // Reserved code drives no reference at all
      refExt_reg <= activeRef_next == `ACS_REF_EXT;
      refSup_reg <= activeRef_next == `ACS_REF_SUP;
      refInt_reg <= activeRef_next == `ACS_REF_INT;
      pos_reg <= pos_next;
      neg_reg <= neg_next;
      diff_reg <= diff_next;
      gain_reg <= gain_next;
      bg_reg <= bg_next;
      gnd_reg <= gnd_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign convIrq = irq_reg;
  assign converterOn = en_reg;
  assign sarStart = start_reg;
  assign sarTick = tick;
  assign refExtPin = refExt_reg;
  assign refSupply = refSup_reg;
  assign refInternal = refInt_reg;
  assign muxPos = pos_reg;
  assign muxNeg = neg_reg;
  assign diffMode = diff_reg;
  assign gainSel = gain_reg;
  assign bandgapSel = bg_reg;
  assign groundSel = gnd_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_abort;
    busy && !en_next;
  endsequence
  property p_abort;
    s_abort |=> !busy ##1 !flag_reg || $past(flag_reg, 2) || $past(complete, 2);
  endproperty
  a_abort: assert property (p_abort) else $error("disable did not abort");

  property p_start_busy;
    wrCcs && pwdata[`ACS_SC_BIT] && pwdata[`ACS_EN_BIT] && !busy |=> busy ##1 busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start bit not busy");

  property p_first_len;
    start && firstPend_next == 1'b0 && (firstPend_reg || (en_next && !en_reg)) |=> len_reg == 5'd25;
  endproperty
  a_first_len: assert property (p_first_len) else $error("first conversion not 25 cycles");

  property p_complete_flag;
    complete && !blocked |=> flag_reg && result_reg == $past(sarData);
  endproperty
  a_complete_flag: assert property (p_complete_flag) else $error("flag or result not updated");

  property p_irq;
    flag_reg && ie_reg && globalIrqEnable |=> convIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_clear_one;
    (wrCcs && pwdata[`ACS_IF_BIT] || irqVectorAck) && !complete |=> !flag_reg;
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("flag not cleared");

  property p_hold_sel;
    busy && $past(busy) && !$past(start) |-> $stable(activeMux_reg) && $stable(activeRef_reg);
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("selection changed mid conversion");

  property p_lock;
    lock_reg |=> $stable(result_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked result changed");

  property p_free_run;
    complete && freeRun && en_next |=> busy && len_reg == 5'd13 && tickCnt_reg == 5'h00;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free running did not restart");

  property p_no_free_edge;
    ts_reg == 3'h0 |-> !trigEdge;
  endproperty
  a_no_free_edge: assert property (p_no_free_edge) else $error("edge from free running source");

endmodule : acs_top

// ==== pkg/acs_cfg.svh ====
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// Register byte offsets on the APB
`define ACS_OFS_CRS 8'h00
`define ACS_OFS_CCS 8'h04
`define ACS_OFS_RLO 8'h08
`define ACS_OFS_RHI 8'h0C
`define ACS_OFS_TRG 8'h10

// Reset values
`define ACS_CRS_RST 8'h00
`define ACS_CCS_RST 8'h00
`define ACS_TRG_RST 3'h0

// channel_reference_select fields
`define ACS_REF_HI 7
`define ACS_REF_LO 6
`define ACS_LADJ_BIT 5
`define ACS_MUX_HI 4

// converter_control_status fields
`define ACS_EN_BIT 7
`define ACS_SC_BIT 6
`define ACS_ATE_BIT 5
`define ACS_IF_BIT 4
`define ACS_IE_BIT 3
`define ACS_PS_HI 2

// Trigger register: trigger_source_select field
`define ACS_TS_HI 7
`define ACS_TS_LO 5

// Reference codes
`define ACS_REF_EXT 2'b00
`define ACS_REF_SUP 2'b01
`define ACS_REF_INT 2'b11

// Channel codes for internal inputs
`define ACS_MUX_BANDGAP 5'h1E
`define ACS_MUX_GROUND 5'h1F

// Conversion lengths in converter clock cycles
`define ACS_FIRST_CYC 5'd25
`define ACS_NORM_CYC 5'd13

`endif

// ==== pkg/acs_pkg.sv ====
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_IDLE = 2'b01,
    ACS_CONV = 2'b10
  } acs_state_t;

  typedef enum logic [1:0] {
    ACS_GAIN_1 = 2'h0,
    ACS_GAIN_10 = 2'h1,
    ACS_GAIN_200 = 2'h2
  } acs_gain_t;

endpackage : acs_pkg

// ==== core/acs_prescaler.sv ====
`timescale 1ns/10ps
module acs_prescaler
  import acs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic clear,
  input wire logic [2:0] prescaleSel,
  output logic tick
);

  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  logic [6:0] divM1;

  // Codes 0 and 1 both divide by two
  assign divM1 = (prescaleSel <= 3'h1) ? 7'h01 : 7'((8'h01 << prescaleSel) - 8'h01);

  always_comb
  begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!run || clear)
    begin
      cnt_next = 7'h00;
    end
    else if (cnt_reg == divM1)
    begin
      cnt_next = 7'h00;
      tick_next = 1'b1;
    end
    else
    begin
      cnt_next = cnt_reg + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_reg <= 7'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  property p_tick_spacing;
    @(posedge clk_sys) disable iff (sys_rst)
    tick_reg |=> !tick_reg;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("prescaler tick repeated");

  property p_tick_divisor;
    @(posedge clk_sys) disable iff (sys_rst)
    run && !clear && $stable(prescaleSel) && cnt_reg == divM1 |=> tick_reg && cnt_reg == 7'h00;
  endproperty
  a_tick_divisor: assert property (p_tick_divisor) else $error("prescaler divisor wrong");

endmodule : acs_prescaler

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`include "acs_cfg.svh"
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin numErrors++; \
  $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb
  import acs_pkg::*;
;
  logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic globalIrqEnable, irqVectorAck, convIrq, converterOn, sarStart, sarTick;
  logic refExtPin, refSupply, refInternal, diffMode, bandgapSel, groundSel, eD;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [9:0] sarData;
  logic [6:0] trigSources;
  logic [2:0] muxPos, muxNeg, eP, eN;
  logic [1:0] eG;
  acs_gain_t gainSel;
  logic [2:0] refExp [4] = '{3'h4, 3'h2, 3'h0, 3'h1};
  int numErrors, samplesChecked, n, c, starts;

  acs_top i_acs_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sarData(sarData), .trigSources(trigSources),
    .globalIrqEnable(globalIrqEnable), .irqVectorAck(irqVectorAck), .convIrq(convIrq),
    .converterOn(converterOn), .sarStart(sarStart), .sarTick(sarTick), .refExtPin(refExtPin),
    .refSupply(refSupply), .refInternal(refInternal), .muxPos(muxPos), .muxNeg(muxNeg),
    .diffMode(diffMode), .gainSel(gainSel), .bandgapSel(bandgapSel), .groundSel(groundSel));

  always #10 clk_sys = ~clk_sys;

  // Every launched conversion must show exactly one start pulse to the core
  always @(posedge clk_sys)
  begin
    if (sarStart === 1'h1)
      starts++;
  end

  task report_and_stop;
    $display("Checks %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // Request held until pready is seen at a rising edge; read data taken there
  task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'h1;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (pready !== 1'h1 && i < 20);
    v = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1)
    begin
      numErrors++;
      $display("Error pready never came");
      report_and_stop;
    end
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task rd(input logic [7:0] a);
    apb(1'h0, a, 8'h0);
  endtask : rd

  // Two idle cycles first so an interrupt level from the previous flag has dropped
  task waitc;
    n = 2;
    repeat (2) @(posedge clk_sys);
    while (convIrq !== 1'h1)
    begin
      @(posedge clk_sys);
      n++;
      if (n > 40000)
      begin
        numErrors++;
        $display("Error completion never came");
        report_and_stop;
      end
    end
  endtask : waitc

  task conv(input logic [7:0] ccs, input int e);
    wr(`ACS_OFS_CCS, ccs);
    waitc;
    `CHK("convTime", 1'h1, (n >= e && n <= e + 4))
  endtask : conv

  task rdres(input logic [7:0] lo, input logic [7:0] hi);
    rd(`ACS_OFS_RLO);
    `CHK("resLow", lo, v[7:0])
    rd(`ACS_OFS_RHI);
    `CHK("resHigh", hi, v[7:0])
  endtask : rdres

  initial
  begin
    clk_sys = 1'h0;
    sys_rst = 1'h1;
    {psel, penable, pwrite, irqVectorAck, globalIrqEnable} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    sarData = 10'h270;
    trigSources = 7'h0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'h0;
    rd(`ACS_OFS_CRS);
    `CHK("crsReset", 32'h0, v)
    rd(`ACS_OFS_CCS);
    `CHK("ccsReset", 32'h0, v)
    rd(8'h14);
    `CHK("unmapped", 33'h100000000, {err, v})
    for (c = 0; c < 32; c++)
    begin
      wr(`ACS_OFS_CRS, 8'(c));
      // Selection is latched, then decoded into the mux flops a cycle later
      repeat (3) @(posedge clk_sys);
      eD = (c >= 8 && c < 30);
      eP = 3'(c);
      eG = 2'h0;
      eN = c[2] ? 3'h2 : 3'h0;
      if (c >= 8 && c < 16)
      begin
        eP = eN + 3'(c[0]);
        eG = c[1] ? 2'h2 : 2'h1;
      end
      else if (c >= 16 && c < 24)
        eN = 3'h1;
      else if (c >= 24)
      begin
        eP = 3'(c - 24);
        eN = 3'h2;
      end
      `CHK("diffMode", eD, diffMode)
      `CHK("internal", {c == 30, c == 31}, {bandgapSel, groundSel})
      if (c < 30)
        `CHK("muxPos", eP, muxPos)
      if (eD)
        `CHK("negGain", {eN, eG}, {muxNeg, 2'(gainSel)})
    end
    for (c = 0; c < 4; c++)
    begin
      wr(`ACS_OFS_CRS, 8'(c << 6));
      repeat (2) @(posedge clk_sys);
      `CHK("reference", refExp[c], {refExtPin, refSupply, refInternal})
    end
    globalIrqEnable <= 1'h1;
    wr(`ACS_OFS_CRS, 8'hED);
    conv(8'hC8, 50);
    `CHK("converterOn", 1'h1, converterOn)
    rd(`ACS_OFS_CCS);
    `CHK("busyDone", 1'h0, v[6])
    rdres(8'h00, 8'h9C);
    wr(`ACS_OFS_CRS, 8'hCD);
    rdres(8'h70, 8'h02);
    for (c = 0; c < 8; c++)
      conv(8'hD8 | 8'(c), 13 * ((c < 2) ? 2 : (1 << c)));
    wr(`ACS_OFS_CCS, 8'h88);
    repeat (2) @(posedge clk_sys);
    `CHK("flagKeep", 1'h1, convIrq)
    globalIrqEnable <= 1'h0;
    repeat (3) @(posedge clk_sys);
    `CHK("irqGlobalOff", 1'h0, convIrq)
    globalIrqEnable <= 1'h1;
    irqVectorAck <= 1'h1;
    @(posedge clk_sys);
    irqVectorAck <= 1'h0;
    repeat (3) @(posedge clk_sys);
    `CHK("vectorClear", 1'h0, convIrq)
    // Slowest prescale keeps the conversion open while selections change
    wr(`ACS_OFS_CRS, 8'h03);
    wr(`ACS_OFS_CCS, 8'hDF);
    rd(`ACS_OFS_CCS);
    `CHK("busy", 1'h1, v[6])
    wr(`ACS_OFS_CRS, 8'h05);
    wr(`ACS_OFS_CCS, 8'h8F);
    `CHK("muxHeld", 3'h3, muxPos)
    rd(`ACS_OFS_CCS);
    `CHK("zeroStart", 1'h1, v[6])
    waitc;
    `CHK("muxAfter", 3'h5, muxPos)
    rd(`ACS_OFS_RLO);
    `CHK("lockLow", 8'h70, v[7:0])
    sarData <= 10'h155;
    conv(8'hD8, 26);
    rd(`ACS_OFS_RHI);
    `CHK("lockHigh", 8'h02, v[7:0])
    conv(8'hD8, 26);
    rdres(8'h55, 8'h01);
    wr(`ACS_OFS_CCS, 8'hDF);
    repeat (10) @(posedge clk_sys);
    wr(`ACS_OFS_CCS, 8'h18);
    repeat (2) @(posedge clk_sys);
    `CHK("enableOff", 1'h0, converterOn)
    repeat (2000) @(posedge clk_sys);
    `CHK("aborted", 1'h0, convIrq)
    rd(`ACS_OFS_CCS);
    `CHK("abortBusy", 1'h0, v[6])
    wr(`ACS_OFS_TRG, 8'h20);
    wr(`ACS_OFS_CCS, 8'hB8);
    trigSources <= 7'h01;
    waitc;
    `CHK("trigger", 1'h1, (n >= 26 && n <= 54))
    trigSources <= 7'h00;
    wr(`ACS_OFS_TRG, 8'h00);
    repeat (5) @(posedge clk_sys);
    rd(`ACS_OFS_CCS);
    `CHK("freeNoEdge", 1'h0, v[6])
    conv(8'hF8, 26);
    wr(`ACS_OFS_CCS, 8'hB8);
    waitc;
    `CHK("freeRestart", 1'h1, (n <= 30))
    wr(`ACS_OFS_CCS, 8'h10);
    `CHK("startPulses", 17, starts)
    report_and_stop;
  end
endmodule : tb
